// >>> include/llhu_pkg.sv
// Constants and types shared by the load decode and execute unit
package llhu_pkg;

  // ----------------------------------------------------------------
  // Data path widths
  // ----------------------------------------------------------------
  localparam int XLEN = 32;
  localparam int REG_W = 5;
  localparam int OPC_W = 6;

  // ----------------------------------------------------------------
  // Instruction field positions
  // ----------------------------------------------------------------
  localparam int OPC_LSB = 26;
  localparam int BASE_LSB = 21;
  localparam int DEST_LSB = 16;
  localparam int FUNC_LSB = 0;
  localparam int IMM_LSB = 0;
  localparam int IMM_W = 16;
  localparam int OFF9_LSB = 7;
  localparam int OFF9_W = 9;
  localparam int EXT_ZERO_BIT = 6;
  localparam int FP_ZERO_LSB = 11;
  localparam int FP_DEST_LSB = 6;

  // ----------------------------------------------------------------
  // Opcode and function encodings
  // ----------------------------------------------------------------
  localparam logic [OPC_W-1:0] OPC_HALF_UNS = 6'h25;
  localparam logic [OPC_W-1:0] OPC_LINKED = 6'h30;
  localparam logic [OPC_W-1:0] OPC_UPPER_IMM = 6'h0F;
  localparam logic [OPC_W-1:0] OPC_EXT_MAJOR = 6'h1F;
  localparam logic [OPC_W-1:0] OPC_FP_EXT_MAJOR = 6'h13;
  localparam logic [OPC_W-1:0] FN_HALF_UNS_UA = 6'h29;
  localparam logic [OPC_W-1:0] FN_LINKED_UA = 6'h2E;
  localparam logic [OPC_W-1:0] FN_FP_DW_IDX_UNAL = 6'h05;

  // ----------------------------------------------------------------
  // Register map (Wishbone byte addresses)
  // ----------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] ADR_STATUS = 8'h04;
  localparam logic [ADR_W-1:0] ADR_FAULT_ADDR = 8'h08;

  // Control register fields
  localparam int CTRL_W = 7;
  localparam int CTRL_EVA_BIT = 0;
  localparam int CTRL_BIG_END_BIT = 1;
  localparam int CTRL_REV_END_BIT = 2;
  localparam int CTRL_CP0_BIT = 3;
  localparam int CTRL_CP1_BIT = 4;
  localparam int CTRL_FPU64_BIT = 5;
  localparam int CTRL_FP_WIDTH_BIT = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

  // Status register fields
  localparam int STAT_LINK_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_FP_DEFINED_BIT = 2;
  localparam int STAT_EXC_LSB = 4;

  // ----------------------------------------------------------------
  // Enumerations and state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EXC_NONE, EXC_TLB_REFILL, EXC_TLB_INVALID, EXC_BUS, EXC_ADDR, EXC_WATCH,
    EXC_RESERVED, EXC_CP_UNUSABLE
  } llhu_exc_e;

  typedef enum logic [2:0] {
    OP_NONE, OP_HALF, OP_HALF_UA, OP_LINK, OP_LINK_UA, OP_UPPER, OP_FP_DW
  } llhu_op_e;

  typedef enum logic [1:0] {ST_IDLE, ST_MEM_LO, ST_MEM_HI} llhu_fsm_e;

  typedef struct packed {
    llhu_fsm_e st;
    llhu_op_e op;
    logic [REG_W-1:0] dest;
    logic [XLEN-1:0] vaddr;
    logic [XLEN-1:0] maddr;
    logic [XLEN-1:0] lsw;
    logic [CTRL_W-1:0] ctrl;
    logic link;
    llhu_exc_e last_exc;
    logic [XLEN-1:0] fault_vaddr;
    logic gpr_we;
    logic [XLEN-1:0] gpr_wdata;
    logic fpr_we;
    logic [2*XLEN-1:0] fpr_wdata;
    logic exc;
    llhu_exc_e exc_code;
    logic wb_ack;
    logic [XLEN-1:0] wb_rdata;
  } llhu_state_s;

endpackage

// >>> verilog/llhu_unit.sv
// Decode and execute unit for halfword, linked, upper-immediate and fp indexed loads
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module llhu_unit (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone register slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [llhu_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [llhu_pkg::XLEN-1:0] wb_dat_i,
  output logic [llhu_pkg::XLEN-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Instruction issue
  input wire logic instr_valid_i,
  input wire logic [llhu_pkg::XLEN-1:0] instr_i,
  input wire logic [llhu_pkg::XLEN-1:0] base_val_i,
  input wire logic [llhu_pkg::XLEN-1:0] index_val_i,
  output logic instr_ready_o,
  // Memory through address translation
  output logic mem_req_o,
  output logic [llhu_pkg::XLEN-1:0] mem_addr_o,
  output logic mem_half_o,
  output logic mem_user_map_o,
  input wire logic mem_ack_i,
  input wire logic [llhu_pkg::XLEN-1:0] mem_rdata_i,
  input wire logic mem_tlb_refill_i,
  input wire logic mem_tlb_invalid_i,
  input wire logic mem_bus_err_i,
  input wire logic mem_watch_i,
  // Atomic sequence
  input wire logic sc_resolve_i,
  output logic link_flag_o,
  // Results and exceptions
  output logic gpr_we_o,
  output logic [llhu_pkg::REG_W-1:0] gpr_waddr_o,
  output logic [llhu_pkg::XLEN-1:0] gpr_wdata_o,
  output logic fpr_we_o,
  output logic [llhu_pkg::REG_W-1:0] fpr_waddr_o,
  output logic [2*llhu_pkg::XLEN-1:0] fpr_wdata_o,
  output logic exc_o,
  output llhu_pkg::llhu_exc_e exc_code_o,
  output logic [llhu_pkg::XLEN-1:0] exc_vaddr_o
);
  import llhu_pkg::*;

  llhu_state_s q;
  llhu_state_s d;

  logic take;
  logic [OPC_W-1:0] opc;
  logic [OPC_W-1:0] fn;
  llhu_op_e dec_op;
  llhu_exc_e dec_exc;
  llhu_exc_e mem_exc;
  logic dec_ua;
  logic [XLEN-1:0] off16;
  logic [XLEN-1:0] off9;
  logic [XLEN-1:0] idx_sum;
  logic [XLEN-1:0] dec_vaddr;
  logic [XLEN-1:0] dec_maddr;
  logic [REG_W-1:0] dec_dest;
  logic [1:0] lane;
  logic [IMM_W-1:0] half_sel;
  logic [XLEN-1:0] rd_mux;
  logic big_end;
  logic rev_end;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  assign take = ce_i && instr_valid_i && instr_ready_o;
  assign opc = instr_i[OPC_LSB +: OPC_W];
  assign fn = instr_i[FUNC_LSB +: OPC_W];
  assign off16 = {{(XLEN-IMM_W){instr_i[IMM_LSB+IMM_W-1]}}, instr_i[IMM_LSB +: IMM_W]};
  assign off9 = {{(XLEN-OFF9_W){instr_i[OFF9_LSB+OFF9_W-1]}}, instr_i[OFF9_LSB +: OFF9_W]};
  assign idx_sum = base_val_i + index_val_i;
  assign big_end = q.ctrl[CTRL_BIG_END_BIT];
  assign rev_end = q.ctrl[CTRL_REV_END_BIT];

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  always_comb begin
    dec_op = OP_NONE;
    case (opc)
      OPC_HALF_UNS: begin
        dec_op = OP_HALF;
      end
      OPC_LINKED: begin
        dec_op = OP_LINK;
      end
      OPC_UPPER_IMM: begin
        if (instr_i[BASE_LSB +: REG_W] == 5'h00) begin
          dec_op = OP_UPPER;
        end
      end
      OPC_EXT_MAJOR: begin
        if (!instr_i[EXT_ZERO_BIT]) begin
          if (fn == FN_HALF_UNS_UA) begin
            dec_op = OP_HALF_UA;
          end
          if (fn == FN_LINKED_UA) begin
            dec_op = OP_LINK_UA;
          end
        end
      end
      OPC_FP_EXT_MAJOR: begin
        if (fn == FN_FP_DW_IDX_UNAL && instr_i[FP_ZERO_LSB +: REG_W] == 5'h00) begin
          dec_op = OP_FP_DW;
        end
      end
      default: begin
        dec_op = OP_NONE;
      end
    endcase
  end

  assign dec_ua = (dec_op == OP_HALF_UA) || (dec_op == OP_LINK_UA);

  // ----------------------------------------------------------------
  // Effective address, lane steering and early exceptions
  // ----------------------------------------------------------------
  always_comb begin
    dec_vaddr = base_val_i + off16;
    dec_maddr = dec_vaddr;
    dec_dest = instr_i[DEST_LSB +: REG_W];
    dec_exc = EXC_NONE;
    case (dec_op)
      OP_HALF_UA, OP_LINK_UA: begin
        dec_vaddr = base_val_i + off9;
      end
      OP_FP_DW: begin
        dec_vaddr = {idx_sum[XLEN-1:3], 3'b000};
        dec_dest = instr_i[FP_DEST_LSB +: REG_W];
      end
      default: begin
        dec_vaddr = base_val_i + off16;
      end
    endcase
    dec_maddr = dec_vaddr;
    if (dec_op == OP_HALF || dec_op == OP_HALF_UA) begin
      dec_maddr[1] = dec_vaddr[1] ^ rev_end;
    end
    if (dec_op == OP_FP_DW) begin
      dec_maddr[2] = dec_vaddr[2] ^ (big_end ^ rev_end);
    end
    if (dec_op == OP_NONE || (dec_ua && !q.ctrl[CTRL_EVA_BIT])) begin
      dec_exc = EXC_RESERVED;
    end else if (dec_ua && !q.ctrl[CTRL_CP0_BIT]) begin
      dec_exc = EXC_CP_UNUSABLE;
    end else if (dec_op == OP_FP_DW && !q.ctrl[CTRL_CP1_BIT]) begin
      dec_exc = EXC_CP_UNUSABLE;
    end else if ((dec_op == OP_HALF || dec_op == OP_HALF_UA) && dec_vaddr[0]) begin
      dec_exc = EXC_ADDR;
    end else if ((dec_op == OP_LINK || dec_op == OP_LINK_UA) && dec_vaddr[1:0] != 2'b00) begin
      dec_exc = EXC_ADDR;
    end
  end

  // ----------------------------------------------------------------
  // Memory answer decode
  // ----------------------------------------------------------------
  always_comb begin
    mem_exc = EXC_NONE;
    if (mem_tlb_refill_i) begin
      mem_exc = EXC_TLB_REFILL;
    end else if (mem_tlb_invalid_i) begin
      mem_exc = EXC_TLB_INVALID;
    // bus error only for user-address halfword
    end else if (mem_bus_err_i && q.op == OP_HALF_UA) begin
      mem_exc = EXC_BUS;
    end else if (mem_watch_i) begin
      mem_exc = EXC_WATCH;
    end
  end

  assign lane = q.vaddr[1:0] ^ {big_end, 1'b0};
  assign half_sel = lane[1] ? mem_rdata_i[31:16] : mem_rdata_i[15:0];

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    case (wb_adr_i)
      ADR_CTRL: begin
        rd_mux[CTRL_W-1:0] = q.ctrl;
      end
      ADR_STATUS: begin
        rd_mux[STAT_LINK_BIT] = q.link;
        rd_mux[STAT_BUSY_BIT] = (q.st != ST_IDLE);
        rd_mux[STAT_FP_DEFINED_BIT] = q.ctrl[CTRL_FPU64_BIT] && q.ctrl[CTRL_FP_WIDTH_BIT];
        rd_mux[STAT_EXC_LSB +: 3] = q.last_exc;
      end
      ADR_FAULT_ADDR: begin
        rd_mux = q.fault_vaddr;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.gpr_we = 1'b0;
    d.fpr_we = 1'b0;
    d.exc = 1'b0;
    d.wb_ack = 1'b0;
    // Register slave: data captured with ack, write lands at the edge after ack rises
    if (wb_cyc_i && wb_stb_i && !q.wb_ack) begin
      d.wb_ack = 1'b1;
      d.wb_rdata = rd_mux;
    end
    if (q.wb_ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL) begin
      d.ctrl = wb_dat_i[CTRL_W-1:0];
    end
    if (sc_resolve_i) begin
      d.link = 1'b0;
    end
    case (q.st)
      ST_IDLE: begin
        if (take) begin
          d.op = dec_op;
          d.dest = dec_dest;
          d.vaddr = dec_vaddr;
          d.maddr = dec_maddr;
          if (dec_exc != EXC_NONE) begin
            d.exc = 1'b1;
            d.exc_code = dec_exc;
            d.last_exc = dec_exc;
            d.fault_vaddr = dec_vaddr;
          end else if (dec_op == OP_UPPER) begin
            d.gpr_we = (dec_dest != 5'h00);
            d.gpr_wdata = {instr_i[IMM_LSB +: IMM_W], 16'h0000};
          end else begin
            d.st = ST_MEM_LO;
          end
        end
      end
      ST_MEM_LO: begin
        if (ce_i && mem_ack_i) begin
          if (mem_exc != EXC_NONE) begin
            d.exc = 1'b1;
            d.exc_code = mem_exc;
            d.last_exc = mem_exc;
            d.fault_vaddr = q.vaddr;
            d.st = ST_IDLE;
          end else begin
            case (q.op)
              OP_HALF, OP_HALF_UA: begin
                d.gpr_we = (q.dest != 5'h00);
                d.gpr_wdata = {16'h0000, half_sel};
                d.st = ST_IDLE;
              end
              OP_LINK, OP_LINK_UA: begin
                d.gpr_we = (q.dest != 5'h00);
                d.gpr_wdata = mem_rdata_i;
                d.link = 1'b1;
                d.st = ST_IDLE;
              end
              OP_FP_DW: begin
                d.lsw = mem_rdata_i;
                d.maddr = q.maddr ^ 32'h0000_0004;
                d.st = ST_MEM_HI;
              end
              default: begin
                d.st = ST_IDLE;
              end
            endcase
          end
        end
      end
      ST_MEM_HI: begin
        if (ce_i && mem_ack_i) begin
          d.st = ST_IDLE;
          if (mem_exc != EXC_NONE) begin
            d.exc = 1'b1;
            d.exc_code = mem_exc;
            d.last_exc = mem_exc;
            d.fault_vaddr = q.vaddr + 32'h0000_0004;
          end else begin
            d.fpr_we = 1'b1;
            d.fpr_wdata = {mem_rdata_i, q.lsw};
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ctrl <= CTRL_RESET;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign instr_ready_o = (q.st == ST_IDLE);
  assign wb_ack_o = q.wb_ack;
  assign wb_dat_o = q.wb_rdata;
  assign mem_req_o = (q.st == ST_MEM_LO) || (q.st == ST_MEM_HI);
  assign mem_addr_o = q.maddr;
  assign mem_half_o = (q.op == OP_HALF) || (q.op == OP_HALF_UA);
  assign mem_user_map_o = (q.op == OP_HALF_UA) || (q.op == OP_LINK_UA);
  assign link_flag_o = q.link;
  assign gpr_we_o = q.gpr_we;
  assign gpr_waddr_o = q.dest;
  assign gpr_wdata_o = q.gpr_wdata;
  assign fpr_we_o = q.fpr_we;
  assign fpr_waddr_o = q.dest;
  assign fpr_wdata_o = q.fpr_wdata;
  assign exc_o = q.exc;
  assign exc_code_o = q.exc_code;
  assign exc_vaddr_o = q.fault_vaddr;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_UPPER_RESULT: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && dec_op == OP_UPPER && dec_dest != 5'h00)
    |=> (gpr_we_o && !exc_o && gpr_wdata_o == {$past(instr_i[15:0]), 16'h0000}))
    else $error("upper immediate result wrong");

  AST_HALF_MISALIGN: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && (dec_op == OP_HALF || dec_op == OP_HALF_UA) && dec_exc != EXC_RESERVED
     && dec_exc != EXC_CP_UNUSABLE && dec_vaddr[0])
    |=> (exc_o && exc_code_o == EXC_ADDR && !mem_req_o))
    else $error("misaligned halfword not trapped");

  AST_LINK_MISALIGN: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && dec_op == OP_LINK && dec_vaddr[1:0] != 2'b00)
    |=> (exc_o && exc_code_o == EXC_ADDR && !mem_req_o
         && link_flag_o == ($past(link_flag_o) && !$past(sc_resolve_i))))
    else $error("misaligned linked load not trapped");

  AST_UA_RESERVED: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && dec_ua && !q.ctrl[CTRL_EVA_BIT]) |=> (exc_o && exc_code_o == EXC_RESERVED))
    else $error("user-address load not reserved");

  AST_UA_CP0: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && dec_ua && q.ctrl[CTRL_EVA_BIT] && !q.ctrl[CTRL_CP0_BIT])
    |=> (exc_o && exc_code_o == EXC_CP_UNUSABLE))
    else $error("coprocessor gate missed");

  AST_LINK_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && q.st == ST_MEM_LO && mem_ack_i && mem_exc == EXC_NONE
     && (q.op == OP_LINK || q.op == OP_LINK_UA)) |=> (link_flag_o && instr_ready_o))
    else $error("link flag not set");

  AST_LINK_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && sc_resolve_i && q.st == ST_IDLE) |=> !link_flag_o)
    else $error("link flag not cleared");

  AST_ZERO_DEST: assert property (@(posedge clk_i) disable iff (rst_i)
    gpr_we_o |-> (gpr_waddr_o != 5'h00))
    else $error("write to register zero");

  AST_FP_SECOND: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && q.st == ST_MEM_LO && mem_ack_i && mem_exc == EXC_NONE && q.op == OP_FP_DW)
    |=> (mem_req_o && mem_addr_o == ($past(mem_addr_o) ^ 32'h0000_0004)))
    else $error("high word address wrong");

  AST_FP_ALIGN: assert property (@(posedge clk_i) disable iff (rst_i)
    (mem_req_o && q.op == OP_FP_DW) |-> (mem_addr_o[1:0] == 2'b00 && q.vaddr[2:0] == 3'b000))
    else $error("indexed address not aligned");

  AST_USER_MAP: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && dec_ua && dec_exc == EXC_NONE) |=> (mem_req_o && mem_user_map_o))
    else $error("user mapping not requested");

  AST_HALF_ZEXT: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && q.st == ST_MEM_LO && mem_ack_i && mem_exc == EXC_NONE && mem_half_o
     && q.dest != 5'h00) |=> (gpr_we_o && gpr_wdata_o[31:16] == 16'h0000))
    else $error("halfword not zero extended");

endmodule // llhu_unit

// >>> tb/llhu_mem_model.sv
// Memory and address translation partner model for the load unit
`timescale 1ns/10ps
module llhu_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request side
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  // Answer timing and error flags to report
  input wire logic slow_i,
  input wire logic [3:0] err_i,
  // Answer
  output logic ack_o,
  output logic [31:0] rdata_o,
  output logic [3:0] flag_o
);
  logic [1:0] cnt;
  wire go = req_i && !ack_o && (!slow_i || cnt == 2'd3);
  always_ff @(posedge clk_i) begin
    ack_o <= !rst_i && go;
    flag_o <= go ? err_i : 4'h0;
    cnt <= (rst_i || go || !req_i) ? 2'd0 : cnt + 2'd1;
    // Idle data toggles so a stale word never passes for an answer
    rdata_o <= rst_i ? 32'h0 : go ? {~addr_i[15:0], addr_i[15:0]} : ~rdata_o;
  end
endmodule // llhu_mem_model

// >>> tb/tb.sv
// Self-checking bench for the load decode and execute unit
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
  import llhu_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, vld = 1'b0, sc = 1'b0, slow = 1'b0, ce = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, ins = 32'h0, bas = 32'h0, idx = 32'h0, rd, wbd, ma, mrd, gwd, enhanced_virtual_addressing;
  logic [3:0] err = 4'h0, mfl;
  logic ack, rdy, mreq, mhalf, muser, mack, link, gwe, fwe, exc, mh, mu;
  logic [4:0] gwa, fwa;
  logic [63:0] fwd;
  llhu_exc_e code;
  int err_total = 0;
  int cmp_count = 0;
  initial forever #4 clk_i = ~clk_i;
  llhu_unit i_llhu_unit (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
    .wb_dat_o(wbd), .wb_ack_o(ack), .instr_valid_i(vld), .instr_i(ins), .base_val_i(bas),
    .index_val_i(idx), .instr_ready_o(rdy), .mem_req_o(mreq), .mem_addr_o(ma),
    .mem_half_o(mhalf), .mem_user_map_o(muser), .mem_ack_i(mack), .mem_rdata_i(mrd),
    .mem_tlb_refill_i(mfl[0]), .mem_tlb_invalid_i(mfl[1]), .mem_bus_err_i(mfl[2]),
    .mem_watch_i(mfl[3]), .sc_resolve_i(sc), .link_flag_o(link), .gpr_we_o(gwe),
    .gpr_waddr_o(gwa), .gpr_wdata_o(gwd), .fpr_we_o(fwe), .fpr_waddr_o(fwa),
    .fpr_wdata_o(fwd), .exc_o(exc), .exc_code_o(code), .exc_vaddr_o(enhanced_virtual_addressing));
  llhu_mem_model i_llhu_mem_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(mreq), .addr_i(ma),
    .slow_i(slow), .err_i(err), .ack_o(mack), .rdata_o(mrd), .flag_o(mfl));
  function automatic logic [31:0] md(input logic [31:0] a);
    return {~a[15:0], a[15:0]};
  endfunction
  // Expected halfword under the big-endian and reverse flags
  function automatic logic [31:0] hx(input logic [31:0] va, input logic big, input logic rev);
    logic [31:0] w;
    w = md({va[31:2], va[1] ^ rev, va[0]});
    return (va[1] ^ big) ? {16'h0000, w[31:16]} : {16'h0000, w[15:0]};
  endfunction
  function automatic logic [31:0] ua(input logic [4:0] rt, input logic [8:0] of, input logic [5:0] f);
    return {OPC_EXT_MAJOR, 5'h01, rt, of, 1'b0, f};
  endfunction
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic lost;
    err_total++;
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, 1'b0, 1'b1);
    print_verdict();
  endtask
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      #1;
      if (ack === 1'b1) break;
    end
    if (n == 20) lost();
    @(posedge clk_i);
    rd = wbd;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic setm(input logic [3:0] e, input logic s);
    @(posedge clk_i);
    err <= e;
    slow <= s;
  endtask
  task automatic issue(input logic [31:0] i, input logic [31:0] b, input logic [31:0] x, input bit q);
    int n;
    @(posedge clk_i);
    {mh, mu} = 2'bxx;
    {ins, bas, idx, vld} <= {i, b, x, 1'b1};
    @(posedge clk_i);
    vld <= 1'b0;
    for (n = 0; n < 40; n++) begin
      #1;
      if (mreq === 1'b1) {mh, mu} = {mhalf, muser};
      if (gwe === 1'b1 || fwe === 1'b1 || exc === 1'b1) break;
      @(posedge clk_i);
    end
    if (n == 40 && !q) lost();
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wbx(0, ADR_CTRL, 0); `CHK(rd, 32'h0)
    wbx(1, ADR_CTRL, 32'hFFFF_FFFF); wbx(0, ADR_CTRL, 0); `CHK(rd, 32'h7F)
    wbx(0, 8'h0C, 0); `CHK(rd, 32'h0)
    $display("registers done");
    issue({OPC_UPPER_IMM, 5'h00, 5'h03, 16'hBEEF}, 0, 0, 0); `CHK({gwa, gwd, exc}, {5'h03, 32'hBEEF_0000, 1'b0})
    issue({OPC_UPPER_IMM, 5'h00, 5'h00, 16'h1234}, 0, 0, 1); `CHK(gwe & (gwa == 5'h00), 1'b0)
    for (int e = 0; e < 4; e++) begin
      wbx(1, ADR_CTRL, {29'h0, e[1], e[0], 1'b0});
      issue({OPC_HALF_UNS, 5'h01, 5'h04, 16'h0002}, 32'h1000, 0, 0); `CHK(gwd, hx(32'h1002, e[0], e[1]))
      `CHK({mh, mu}, 2'b10)
    end
    issue({OPC_HALF_UNS, 5'h01, 5'h04, 16'h0003}, 32'h1000, 0, 0); `CHK({code, enhanced_virtual_addressing}, {EXC_ADDR, 32'h1003})
    wbx(1, ADR_CTRL, 0);
    issue(ua(5'h05, 9'h1FE, FN_HALF_UNS_UA), 32'h2004, 0, 0); `CHK(code, EXC_RESERVED)
    wbx(1, ADR_CTRL, 32'h1);
    issue(ua(5'h05, 9'h1FE, FN_HALF_UNS_UA), 32'h2004, 0, 0); `CHK(code, EXC_CP_UNUSABLE)
    wbx(1, ADR_CTRL, 32'h9);
    setm(4'h0, 1);
    issue(ua(5'h05, 9'h1FE, FN_HALF_UNS_UA), 32'h2004, 0, 0); `CHK({gwa, gwd}, {5'h05, hx(32'h2002, 0, 0)})
    `CHK({mh, mu}, 2'b11)
    issue(ua(5'h05, 9'h001, FN_HALF_UNS_UA), 32'h2000, 0, 0); `CHK(code, EXC_ADDR)
    issue(ua(5'h07, 9'h004, FN_LINKED_UA), 32'h5000, 0, 0); `CHK({gwd, link}, {md(32'h5004), 1'b1})
    `CHK({mh, mu}, 2'b01)
    $display("halfword done");
    setm(4'h3, 0);
    issue({OPC_HALF_UNS, 5'h01, 5'h04, 16'h0000}, 32'h1000, 0, 0); `CHK(code, EXC_TLB_REFILL)
    setm(4'hC, 0);
    issue(ua(5'h05, 9'h1FE, FN_HALF_UNS_UA), 32'h2004, 0, 0); `CHK(code, EXC_BUS)
    issue({OPC_HALF_UNS, 5'h01, 5'h04, 16'h0000}, 32'h1000, 0, 0); `CHK(code, EXC_WATCH)
    setm(4'h4, 0);
    issue({OPC_LINKED, 5'h01, 5'h06, 16'hFFFC}, 32'h3008, 0, 0); `CHK({exc, gwd, link}, {1'b0, md(32'h3004), 1'b1})
    `CHK({mh, mu}, 2'b00)
    // Frozen clock enable must swallow a store-conditional pulse
    @(posedge clk_i) {ce, sc} <= 2'b01;
    @(posedge clk_i) {ce, sc} <= 2'b10;
    #1 `CHK(link, 1'b1)
    @(posedge clk_i) sc <= 1'b1;
    @(posedge clk_i) sc <= 1'b0;
    #1 `CHK(link, 1'b0)
    setm(4'h0, 0);
    issue({OPC_LINKED, 5'h01, 5'h00, 16'h0000}, 32'h3000, 0, 1); `CHK({gwe & (gwa == 5'h00), link}, 2'b01)
    issue({OPC_LINKED, 5'h01, 5'h06, 16'h0002}, 32'h3004, 0, 0); `CHK(code, EXC_ADDR)
    wbx(0, ADR_FAULT_ADDR, 0); `CHK(rd, 32'h3006)
    wbx(1, ADR_CTRL, 0);
    issue(ua(5'h07, 9'h004, FN_LINKED_UA), 32'h5000, 0, 0); `CHK(code, EXC_RESERVED)
    $display("linked done");
    for (int m = 0; m < 2; m++) begin
      wbx(1, ADR_CTRL, {25'h0, 5'h1C, m[0], 1'b0});
      wbx(0, ADR_STATUS, 0); `CHK(rd, 32'h65)
      issue({OPC_FP_EXT_MAJOR, 5'h01, 5'h02, 5'h00, 5'h08, FN_FP_DW_IDX_UNAL}, 32'h4003, 32'h2, 0);
      `CHK({exc, fwa}, {1'b0, 5'h08})
      `CHK(fwd, {md(32'h4004 ^ {m[0], 2'b00}), md(32'h4000 ^ {m[0], 2'b00})})
    end
    $display("fp load done");
    print_verdict();
  end
endmodule // tb
